// File: verilog/caf_apply.sv
// Action field applier: match_identifier merge, forced pipeline point, next key type and frame pointer advance
`timescale 1ns/10ps
`default_nettype none
`include "caf_regs.svh"

// Function
// - Masked bits take action match identifier
// - Nonzero force control overrides pipeline point
// - Decode force: none, extract, inject, loopback
// - Inject: select picks plain or masquerade
// - Loopback: select picks queue or assembler
// - Reduced layout uses 3-bit point code
// - Non-reduced layouts use 5-bit point code
// - Next key type forces next key
// - Code 5 picks triple VLAN variant
// - Code 8 puts destination into source fields
// - Code 15 completes classification, stops lookups
// - Add word offset times four
// - Add halfword offset times two
// - Skipped reserved labels not counted again
// - Type move first, then offsets
// - Type move: none, Ethernet, IP+Ethernet
// - Merged identifier goes to header result
module caf_apply (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire caf_pkg::caf_action_t action_i,
	input wire caf_pkg::caf_context_t context_i,
	output logic res_valid_o,
	output var caf_pkg::caf_result_t result_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`CAF_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	import caf_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Field gating per layout
	caf_action_t act;
	logic [3:0] tri_vlan_sel;

	always_comb begin
		act = action_i;
		// Fields the layout does not carry must not cause overrides
		if (action_i.layout != CAF_LAYOUT_FULL) begin
			act.match_identifier_override_mask = 12'h000;
		end
		if (action_i.layout == CAF_LAYOUT_REDUCED) begin
			act.forced_pipeline_point = 5'h00;
			act.pointer_halfword_offset = 5'h00;
		end else begin
			act.forced_pipeline_point_short = 3'h0;
			act.pointer_word_offset = 2'h0;
		end
		if (action_i.layout == CAF_LAYOUT_FULL) begin
			act.type_based_pointer_move = `CAF_MOVE_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result computation
	caf_result_t calc;
	logic [7:0] moved_ptr;
	logic ip_present;

	always_comb begin
		calc.header_classification_result = (context_i.match_identifier & ~act.match_identifier_override_mask)
			| (act.match_identifier & act.match_identifier_override_mask);

		calc.pipeline_point_short = context_i.pipeline_point_short;
		calc.pipeline_point = context_i.pipeline_point;
		calc.pipeline_action = context_i.pipeline_action;
		if (act.pipeline_force_control != `CAF_FORCE_NONE) begin
			if (act.layout == CAF_LAYOUT_REDUCED) begin
				calc.pipeline_point_short = 1'b1;
				calc.pipeline_point = {2'h0, act.forced_pipeline_point_short};
			end else begin
				calc.pipeline_point_short = 1'b0;
				calc.pipeline_point = act.forced_pipeline_point;
			end
			case (act.pipeline_force_control)
				`CAF_FORCE_XTR: begin
					calc.pipeline_action = CAF_ACT_EXTRACT;
				end
				`CAF_FORCE_INJ: begin
					calc.pipeline_action = act.pipeline_action_select ? CAF_ACT_MASQ_INJECT : CAF_ACT_INJECT;
				end
				default: begin
					calc.pipeline_action = act.pipeline_action_select ? CAF_ACT_ASM_LOOPBACK
						: CAF_ACT_QS_LOOPBACK;
				end
			endcase
		end

		// Incoming pointer already sits past skipped reserved labels, so no correction here
		ip_present = (context_i.ip_version == `CAF_IPVER_4) || (context_i.ip_version == `CAF_IPVER_6);
		moved_ptr = context_i.frame_pointer;
		case (act.type_based_pointer_move)
			`CAF_MOVE_ETH: begin
				if (context_i.frame_type == CAF_FT_ETH) begin
					moved_ptr = context_i.frame_pointer + context_i.eth_layer_len;
				end
			end
			`CAF_MOVE_IP_ETH: begin
				// IP header length includes any IPv4 options
				if (context_i.frame_type == CAF_FT_ETH) begin
					moved_ptr = context_i.frame_pointer + context_i.eth_layer_len + context_i.ip_header_len;
				end else if (context_i.frame_type == CAF_FT_CW && ip_present) begin
					moved_ptr = context_i.frame_pointer + context_i.ip_header_len;
				end
			end
			default: begin
				moved_ptr = context_i.frame_pointer;
			end
		endcase
		// Pointer is 8 bits wide; offsets past 255 wrap, as the rewriter cannot reach them anyway
		calc.frame_pointer = moved_ptr
			+ {4'h0, act.pointer_word_offset, 2'h0}
			+ {2'h0, act.pointer_halfword_offset, 1'b0};

		calc.next_key = {1'b0, act.next_key_type};
		if (act.next_key_type == `CAF_NK_TRI_VLAN && tri_vlan_sel[context_i.lookup_index]) begin
			calc.next_key = `CAF_KEY_TRI_VLAN_IDX;
		end
		calc.classification_complete = context_i.classification_complete
			| (act.next_key_type == `CAF_NK_DONE);
		calc.key_smac = context_i.smac;
		calc.key_ipv4_sip = context_i.ipv4_sip;
		if (act.next_key_type == `CAF_NK_NORMAL_DST) begin
			calc.key_smac = context_i.dmac;
			calc.key_ipv4_sip = context_i.ipv4_dip;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result registers, one cycle after the request
	caf_result_t next_result_o;
	logic next_res_valid_o;
	logic [31:0] action_count;
	logic [31:0] next_action_count;

	assign req_ready_o = 1'b1;

	always_comb begin
		next_res_valid_o = req_valid_i;
		next_result_o = result_o;
		next_action_count = action_count;
		if (req_valid_i) begin
			next_result_o = calc;
			next_action_count = action_count + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			res_valid_o <= 1'b0;
			result_o <= '0;
			action_count <= 32'h0000_0000;
		end else begin
			res_valid_o <= next_res_valid_o;
			result_o <= next_result_o;
			action_count <= next_action_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: acks one cycle after the strobe, for one cycle
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] next_wb_dat_o;
	logic next_wb_ack_o;
	logic wb_req;
	logic [31:0] byte_mask;

	// Lookup index 3 has no variant bit; padding keeps the index in range and reads it as plain
	assign tri_vlan_sel = {1'b0, ctrl[`CAF_LOOKUPS-1:0]};
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	generate
		for (genvar b = 0; b < 4; b++) begin : g_lane
			assign byte_mask[8*b +: 8] = {8{wb_sel_i[b]}};
		end
	endgenerate

	always_comb begin
		next_wb_ack_o = wb_req;
		next_ctrl = ctrl;
		next_wb_dat_o = 32'h0000_0000;
		if (wb_req) begin
			if (wb_adr_i == `CAF_OFF_CTRL) begin
				next_wb_dat_o = ctrl;
				if (wb_we_i) begin
					// Only the per-lookup variant bits exist; the rest stay zero
					next_ctrl = ((ctrl & ~byte_mask) | (wb_dat_i & byte_mask))
						& {{(32-`CAF_LOOKUPS){1'b0}}, {`CAF_LOOKUPS{1'b1}}};
				end
			end else if (wb_adr_i == `CAF_OFF_STATUS) begin
				next_wb_dat_o = 32'h0000_0000;
				next_wb_dat_o[11:0] = result_o.header_classification_result;
				next_wb_dat_o[`CAF_ST_KEY_LSB +: 5] = result_o.next_key;
				next_wb_dat_o[`CAF_ST_DONE_BIT] = result_o.classification_complete;
				next_wb_dat_o[`CAF_ST_SHORT_BIT] = result_o.pipeline_point_short;
			end else if (wb_adr_i == `CAF_OFF_COUNT) begin
				next_wb_dat_o = action_count;
			end else begin
				next_wb_dat_o = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl <= `CAF_CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			wb_ack_o <= next_wb_ack_o;
			wb_dat_o <= next_wb_dat_o;
		end
	end

endmodule
`default_nettype wire

// File: shared/caf_regs.svh
// Register offsets, reset values and field constants for the action field applier
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH

`define CAF_ADDR_W 4
`define CAF_OFF_CTRL 4'h0
`define CAF_OFF_STATUS 4'h4
`define CAF_OFF_COUNT 4'h8
`define CAF_CTRL_RST 32'h0000_0000
`define CAF_LOOKUPS 3
`define CAF_ST_KEY_LSB 16
`define CAF_ST_DONE_BIT 21
`define CAF_ST_SHORT_BIT 22

`define CAF_MID_W 12
`define CAF_PT_W 5
`define CAF_PTS_W 3
`define CAF_FP_W 8
`define CAF_W32_SHIFT 2
`define CAF_W16_SHIFT 1

`define CAF_FORCE_NONE 2'h0
`define CAF_FORCE_XTR 2'h1
`define CAF_FORCE_INJ 2'h2
`define CAF_FORCE_LBK 2'h3

`define CAF_MOVE_NONE 2'h0
`define CAF_MOVE_ETH 2'h1
`define CAF_MOVE_IP_ETH 2'h2

`define CAF_NK_DEFAULT 4'h0
`define CAF_NK_TRI_VLAN 4'h5
`define CAF_NK_NORMAL_DST 4'h8
`define CAF_NK_DONE 4'hF
`define CAF_KEY_TRI_VLAN_IDX 5'h10

`define CAF_IPVER_4 4'h4
`define CAF_IPVER_6 4'h6

`endif

// File: shared/caf_pkg.sv
// Types shared by the action field applier and its users
package caf_pkg;

	typedef enum logic [1:0] {
		CAF_LAYOUT_LABEL = 2'h0,
		CAF_LAYOUT_REDUCED = 2'h1,
		CAF_LAYOUT_CLASSIFY = 2'h2,
		CAF_LAYOUT_FULL = 2'h3
	} caf_layout_t;

	typedef enum logic [1:0] {
		CAF_FT_ETH = 2'h0,
		CAF_FT_CW = 2'h1,
		CAF_FT_LABEL = 2'h2,
		CAF_FT_DATA = 2'h3
	} caf_frame_type_t;

	typedef enum logic [2:0] {
		CAF_ACT_NONE = 3'h0,
		CAF_ACT_EXTRACT = 3'h1,
		CAF_ACT_INJECT = 3'h2,
		CAF_ACT_MASQ_INJECT = 3'h3,
		CAF_ACT_QS_LOOPBACK = 3'h4,
		CAF_ACT_ASM_LOOPBACK = 3'h5
	} caf_pipe_action_t;

	// Matched entry action word, already split into fields
	typedef struct packed {
		caf_layout_t layout;
		logic [11:0] match_identifier;
		logic [11:0] match_identifier_override_mask;
		logic [1:0] pipeline_force_control;
		logic pipeline_action_select;
		logic [4:0] forced_pipeline_point;
		logic [2:0] forced_pipeline_point_short;
		logic [3:0] next_key_type;
		logic [1:0] pointer_word_offset;
		logic [4:0] pointer_halfword_offset;
		logic [1:0] type_based_pointer_move;
	} caf_action_t;

	// Per-frame state entering this lookup
	typedef struct packed {
		logic [1:0] lookup_index;
		logic [11:0] match_identifier;
		logic pipeline_point_short;
		logic [4:0] pipeline_point;
		caf_pipe_action_t pipeline_action;
		logic [7:0] frame_pointer;
		caf_frame_type_t frame_type;
		logic [3:0] ip_version;
		logic [7:0] eth_layer_len;
		logic [7:0] ip_header_len;
		logic classification_complete;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [31:0] ipv4_dip;
		logic [31:0] ipv4_sip;
	} caf_context_t;

	// Result handed to the next key generator and the frame pipeline
	typedef struct packed {
		logic [11:0] header_classification_result;
		logic pipeline_point_short;
		logic [4:0] pipeline_point;
		caf_pipe_action_t pipeline_action;
		logic [7:0] frame_pointer;
		logic [4:0] next_key;
		logic classification_complete;
		logic [47:0] key_smac;
		logic [31:0] key_ipv4_sip;
	} caf_result_t;

endpackage

// File: verif/caf_apply_assertions.sv
// Port checks for the action field applier
`timescale 1ns/10ps
`default_nettype none
module caf_apply_chk (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire caf_pkg::caf_action_t action_i,
	input wire caf_pkg::caf_context_t context_i,
	input wire logic res_valid_o,
	input wire caf_pkg::caf_result_t result_o
);
	import caf_pkg::*;
	wire caf_action_t a = action_i;
	wire caf_context_t c = context_i;
	wire caf_result_t r = result_o;
	wire logic v = req_valid_i;
	wire logic [1:0] f = action_i.pipeline_force_control;
	wire logic s = action_i.pipeline_action_select;
	logic [11:0] mid;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Merge kept aside so the check does not lean on the result register
	always_ff @(posedge sys_clk_i)
		mid <= (c.match_identifier & ~a.match_identifier_override_mask)
			| (a.match_identifier & a.match_identifier_override_mask);
	////////////////////////////////////////
	property p_resp; v |=> res_valid_o; endproperty
	a_resp: assert property (p_resp) else $error("no result after request");
	property p_mid; v && a.layout == CAF_LAYOUT_FULL |=> r.header_classification_result == mid; endproperty
	a_mid: assert property (p_mid) else $error("match_identifier merge wrong");
	property p_keep; v && f == 2'h0 |=> r.pipeline_point == $past(c.pipeline_point); endproperty
	a_keep: assert property (p_keep) else $error("point changed without force");
	property p_xtr; v && f == 2'h1 |=> r.pipeline_action == CAF_ACT_EXTRACT; endproperty
	a_xtr: assert property (p_xtr) else $error("extract not set");
	property p_inj;
		v && f == 2'h2 |=> r.pipeline_action == ($past(s) ? CAF_ACT_MASQ_INJECT : CAF_ACT_INJECT);
	endproperty
	a_inj: assert property (p_inj) else $error("inject kind wrong");
	property p_lbk;
		v && f == 2'h3 |=> r.pipeline_action == ($past(s) ? CAF_ACT_ASM_LOOPBACK : CAF_ACT_QS_LOOPBACK);
	endproperty
	a_lbk: assert property (p_lbk) else $error("loopback kind wrong");
	property p_done; v && a.next_key_type == 4'hF |=> r.classification_complete; endproperty
	a_done: assert property (p_done) else $error("not complete");
	property p_dst; v && a.next_key_type == 4'h8 |=> r.key_smac == $past(c.dmac); endproperty
	a_dst: assert property (p_dst) else $error("destination key wrong");
	c_lbk: cover property (v && f == 2'h3 && s);
	c_b2b: cover property (v [*3]);
	c_done: cover property (v && a.next_key_type == 4'hF);
endmodule
bind caf_apply caf_apply_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
	.action_i(action_i), .context_i(context_i), .res_valid_o(res_valid_o), .result_o(result_o));
`default_nettype wire

// File: verif/caf_next_sink.sv
// Next key generator stand-in that takes each result as it appears
`timescale 1ns/10ps
`default_nettype none
module caf_next_sink (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic res_valid_i,
	output logic [15:0] taken_o
);
	// No stall path exists, so taking every pulse is the honest model
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i)
			taken_o <= 16'h0000;
		else if (res_valid_i)
			taken_o <= taken_o + 16'h0001;
	end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the action field applier
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import caf_pkg::*;
	typedef struct {
		caf_layout_t l;
		logic [1:0] f;
		logic s;
		logic [3:0] k;
		logic [1:0] w;
		logic [4:0] h;
		logic [1:0] m;
		caf_pipe_action_t ea;
		logic [7:0] ep;
	} caf_row_t;
	logic clk, rst, req, cyc, stb, we, rv, ack, rdy;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, wq, failures, total_checks;
	logic [15:0] taken;
	caf_action_t act;
	caf_context_t ctx;
	caf_result_t res;
	caf_row_t rows [8];
	int cyc_n;
	caf_apply DUT (.sys_clk_i(clk), .sys_rst_i(rst), .req_valid_i(req), .req_ready_o(rdy),
		.action_i(act), .context_i(ctx), .res_valid_o(rv), .result_o(res), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	caf_next_sink u_sink (.sys_clk_i(clk), .sys_rst_i(rst), .res_valid_i(rv), .taken_o(taken));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			failures++;
			give_verdict();
		end
	end
	////////////////////////////////////////
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Ends on ack; if ack never comes, only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		wq = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task drive(input caf_row_t w);
		act.layout <= w.l;
		act.pipeline_force_control <= w.f;
		act.pipeline_action_select <= w.s;
		act.next_key_type <= w.k;
		act.pointer_word_offset <= w.w;
		act.pointer_halfword_offset <= w.h;
		act.type_based_pointer_move <= w.m;
		req <= 1'b1;
	endtask
	task chk_row(input caf_row_t w);
		chk("valid", 1'b1, rv);
		chk("mid", w.l == CAF_LAYOUT_FULL ? 12'hACA : 12'hA5A, res.header_classification_result);
		chk("act", w.ea, res.pipeline_action);
		chk("pt", w.f == 2'h0 ? 5'h07 : w.l == CAF_LAYOUT_REDUCED ? 5'h05 : 5'h10, res.pipeline_point);
		chk("short", w.f != 2'h0 && w.l == CAF_LAYOUT_REDUCED, res.pipeline_point_short);
		chk("fp", w.ep, res.frame_pointer);
		chk("key", {1'b0, w.k}, res.next_key);
		chk("smac", w.k == 4'h8 ? 48'hD : 48'h5, res.key_smac);
		chk("sip", w.k == 4'h8 ? 32'hDD : 32'h55, res.key_ipv4_sip);
		chk("done", w.k == 4'hF, res.classification_complete);
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 32'h0 && total_checks > 32'h0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		failures = 32'h0;
		total_checks = 32'h0;
		cyc_n = 0;
		rst = 1'b1;
		req = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		act = '0;
		act.match_identifier = 12'h3C3;
		act.match_identifier_override_mask = 12'h0F0;
		act.forced_pipeline_point = 5'h10;
		act.forced_pipeline_point_short = 3'h5;
		ctx = '0;
		ctx.match_identifier = 12'hA5A;
		ctx.pipeline_point = 5'h07;
		ctx.frame_pointer = 8'h10;
		ctx.ip_version = 4'h4;
		ctx.eth_layer_len = 8'h0E;
		ctx.ip_header_len = 8'h14;
		ctx.dmac = 48'hD;
		ctx.smac = 48'h5;
		ctx.ipv4_dip = 32'hDD;
		ctx.ipv4_sip = 32'h55;
		// Pointer starts at 0x10, Ethernet layer 0x0E, IP header 0x14
		rows = '{'{CAF_LAYOUT_FULL, 2'h0, 1'b0, 4'h0, 2'h3, 5'h01, 2'h2, CAF_ACT_NONE, 8'h12},
			'{CAF_LAYOUT_CLASSIFY, 2'h1, 1'b0, 4'h7, 2'h0, 5'h1F, 2'h1, CAF_ACT_EXTRACT, 8'h5C},
			'{CAF_LAYOUT_REDUCED, 2'h2, 1'b0, 4'h1, 2'h3, 5'h05, 2'h2, CAF_ACT_INJECT, 8'h3E},
			'{CAF_LAYOUT_LABEL, 2'h2, 1'b1, 4'h6, 2'h2, 5'h02, 2'h0, CAF_ACT_MASQ_INJECT, 8'h14},
			'{CAF_LAYOUT_LABEL, 2'h3, 1'b0, 4'h9, 2'h0, 5'h00, 2'h3, CAF_ACT_QS_LOOPBACK, 8'h10},
			'{CAF_LAYOUT_REDUCED, 2'h3, 1'b1, 4'hC, 2'h1, 5'h00, 2'h1, CAF_ACT_ASM_LOOPBACK, 8'h22},
			'{CAF_LAYOUT_CLASSIFY, 2'h0, 1'b0, 4'hF, 2'h0, 5'h1F, 2'h2, CAF_ACT_NONE, 8'h70},
			'{CAF_LAYOUT_CLASSIFY, 2'h1, 1'b1, 4'h8, 2'h0, 5'h00, 2'h0, CAF_ACT_EXTRACT, 8'h10}};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, 4'h0, 32'h0);
		chk("ctrl_rst", 32'h0, wq);
		chk("ready", 1'b1, rdy);
		// Rows go in back to back, one per cycle
		for (int i = 0; i <= 8; i++) begin
			@(posedge clk);
			if (i < 8)
				drive(rows[i]);
			else
				req <= 1'b0;
			#1;
			if (i > 0)
				chk_row(rows[i - 1]);
		end
		@(posedge clk);
		#1;
		chk("idle", 1'b0, rv);
		chk("taken", 16'h8, taken);
		wb(1'b0, 4'h8, 32'h0);
		chk("count", 32'h8, wq);
		wb(1'b0, 4'h4, 32'h0);
		chk("status", 32'h0008_0A5A, wq);
		wb(1'b1, 4'h0, 32'hFFFFFFFF);
		wb(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h7, wq);
		wb(1'b1, 4'hC, 32'h1);
		wb(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, wq);
		// Index 3 has no variant bit, so code 5 stays plain there
		for (int j = 0; j < 32; j++) begin
			@(posedge clk);
			act.next_key_type <= j[3:0];
			ctx.lookup_index <= j[4] ? 2'h3 : 2'h0;
			req <= 1'b1;
			@(posedge clk);
			req <= 1'b0;
			#1;
			chk("next", (j[3:0] == 4'h5 && !j[4]) ? 5'h10 : {1'b0, j[3:0]}, res.next_key);
		end
		@(posedge clk);
		req <= 1'b1;
		rst <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		#1;
		chk("rst_valid", 1'b0, rv);
		chk("rst_res", 1'b0, |res);
		@(posedge clk);
		rst <= 1'b0;
		wb(1'b0, 4'h8, 32'h0);
		chk("rst_count", 32'h0, wq);
		give_verdict();
	end
endmodule
`default_nettype wire
